// >>> hdl/rfp_pkg.sv
// How it works
// RQ1 - Six pins, each with 2-bit route, reset zero
// RQ2 - Clock output divides reference, RC, or off
// RQ3 - Mode settled flag sets per mode, clears on change except a change into sleep, which sets it
// RQ4 - Receive settled after level, gain, frequency steps
// RQ5 - Transmit settled after amplifier ramp-up
// RQ6 - Lock flag follows synthesizer lock in active modes
// RQ7 - Level flag above trigger; leave receive or write clears
// RQ8 - Timeout flag on expiry; clears leaving receive, emptying
// RQ9 - Intermediate flag follows intermediate mode entry and exit
// RQ10 - Frame start on sync plus address; clear rules
// RQ11 - Queue full exactly at 66 bytes
// RQ12 - Queue occupied with one or more bytes
// RQ13 - Above-mark strictly greater than watermark
// RQ14 - Overflow flag outside sleep; writing one flushes queue
// RQ15 - Frame transmitted flag in transmit, clears leaving
// RQ16 - Frame received after last byte, check if auto-clear
// RQ17 - Check pass flag in receive, clears when empty
// RQ18 - Level trigger register resets to 0xe4
// RQ19 - Listen start limit times 16 bits, zero disables
// RQ20 - Post detect limit times 16 bits, zero disables
// RQ21 - Auto-clear failing check flushes and restarts reception
// RQ22 - Measured level register resets to 0xff
// RQ23 - Reading flag registers has no side effect
// RQ24 - Route code selects per-mode source signal
package rfp_pkg;

  localparam logic [5:0] IDX_MEASURED_LEVEL = 6'h24;
  localparam logic [5:0] IDX_PIN_FUNCTION_SELECT_A = 6'h25;
  localparam logic [5:0] IDX_PIN_FUNCTION_SELECT_B = 6'h26;
  localparam logic [5:0] IDX_EVENT_FLAGS_A = 6'h27;
  localparam logic [5:0] IDX_EVENT_FLAGS_B = 6'h28;
  localparam logic [5:0] IDX_SIGNAL_LEVEL_THRESHOLD = 6'h29;
  localparam logic [5:0] IDX_RECEIVE_START_TIMEOUT = 6'h2a;
  localparam logic [5:0] IDX_POST_DETECT_TIMEOUT = 6'h2b;

  localparam logic [7:0] RST_PIN_MAP = 8'h00;
  localparam logic [2:0] RST_REF_DIVIDER = 3'h7;
  localparam logic [7:0] RST_LEVEL_TRIGGER = 8'he4;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_MEASURED_LEVEL = 8'hff;

  localparam int BIT_OP_SETTLED = 7;
  localparam int BIT_LEVEL = 3;
  localparam int BIT_FRAME_START = 0;
  localparam int BIT_OVERFLOW = 4;

  localparam logic [2:0] CLK_SEL_RC = 3'h6;
  localparam logic [2:0] CLK_SEL_OFF = 3'h7;

  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;

  localparam int TMO_UNIT_BITS = 16;
  localparam int QUEUE_BYTES = 66;

endpackage

// >>> hdl/rfp_clk_div.sv
module rfp_clk_div
  import rfp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Reference and selection
  input wire logic ref_tick,
  input wire logic rc_osc_in,
  input wire logic [2:0] ref_divider_select,
  // Outputs
  output logic clk_out,
  output logic rc_osc_enable
);

  logic [4:0] cnt;
  logic [4:0] half;
  logic wrap;

  // Last count of each half period of the divided reference (ticks per half period minus one)
  assign half = 5'((6'h01 << ref_divider_select) - 6'h01);
  assign wrap = cnt >= half;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 5'h00;
      clk_out <= 1'b0;
      rc_osc_enable <= 1'b0;
    end
    else
    begin
      rc_osc_enable <= ref_divider_select == CLK_SEL_RC; // see RQ2
      if (ref_divider_select == CLK_SEL_OFF)
      begin
        cnt <= 5'h00;
        clk_out <= 1'b0; // see RQ2
      end
      else if (ref_divider_select == CLK_SEL_RC)
      begin
        cnt <= 5'h00;
        clk_out <= rc_osc_in; // see RQ2
      end
      else if (ref_tick)
      begin
        cnt <= wrap ? 5'h00 : cnt + 5'h01;
        if (wrap)
        begin
          clk_out <= !clk_out; // see RQ2
        end
      end
    end
  end

endmodule

// >>> hdl/rfp_flags.sv
// Our own choice: the APB slave port.
module rfp_flags
  import rfp_pkg::*;
#(
  parameter int QUEUE_DEPTH = QUEUE_BYTES
)
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operating mode and modem
  input wire logic [2:0] op_mode,
  input wire logic intermediate_active,
  input wire logic packet_mode,
  input wire logic xo_running,
  input wire logic pll_locked,
  input wire logic sampling_started,
  input wire logic rx_chain_done,
  input wire logic pa_ramp_done,
  input wire logic level_valid,
  input wire logic [7:0] level_sample,
  input wire logic bit_tick,
  // Packet engine and queue
  input wire logic sync_seen,
  input wire logic addr_filter_on,
  input wire logic addr_ok,
  input wire logic [6:0] fifo_count,
  input wire logic [6:0] queue_watermark,
  input wire logic fifo_overrun,
  input wire logic tx_frame_done,
  input wire logic rx_last_byte,
  input wire logic crc_on,
  input wire logic crc_good,
  input wire logic keep_on_check_fail,
  output logic fifo_flush,
  output logic restart_rx,
  // Pins
  input wire logic [23:0] route_src,
  output logic [5:0] pin_out,
  input wire logic ref_tick,
  input wire logic rc_osc_in,
  output logic clk_out,
  output logic rc_osc_enable
);

  function automatic logic tmo_due(input logic [11:0] cnt, input logic [7:0] lim);
    return (cnt + 12'h001) == 12'(12'(lim) * 12'(TMO_UNIT_BITS));
  endfunction

  // Register storage
  logic [7:0] pin_function_select_a;
  logic [5:0] pin_function_select_b;
  logic [7:0] level_trigger;
  logic [7:0] listen_start_limit;
  logic [7:0] post_detect_limit;
  logic [7:0] measured_level;
  logic [2:0] ref_divider_select;
  // Flags
  logic op_state_settled;
  logic receive_settled;
  logic transmit_settled;
  logic synth_locked_flag;
  logic level_flag;
  logic timeout_flag;
  logic intermediate_state_flag;
  logic frame_start_detected;
  logic queue_full_flag;
  logic queue_occupied_flag;
  logic queue_above_mark_flag;
  logic queue_overflow_flag;
  logic frame_transmitted_flag;
  logic frame_received_flag;
  logic check_pass_flag;
  // Timeouts
  logic [2:0] prev_mode;
  logic st_run;
  logic pd_run;
  logic [11:0] st_cnt;
  logic [11:0] pd_cnt;
  // Bus decode
  logic acc;
  logic wr;
  logic [5:0] idx;
  logic mapped;
  logic wr_a;
  logic wr_b;
  logic wr_fa;
  logic wr_fb;
  logic wr_th;
  logic wr_t1;
  logic wr_t2;
  logic [7:0] flags_a;
  logic [7:0] flags_b;
  logic [7:0] rd_byte;

  assign acc = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx >= IDX_MEASURED_LEVEL) &&
                  (idx <= IDX_POST_DETECT_TIMEOUT);
  assign wr_a = wr && idx == IDX_PIN_FUNCTION_SELECT_A;
  assign wr_b = wr && idx == IDX_PIN_FUNCTION_SELECT_B;
  assign wr_fa = wr && idx == IDX_EVENT_FLAGS_A;
  assign wr_fb = wr && idx == IDX_EVENT_FLAGS_B;
  assign wr_th = wr && idx == IDX_SIGNAL_LEVEL_THRESHOLD;
  assign wr_t1 = wr && idx == IDX_RECEIVE_START_TIMEOUT;
  assign wr_t2 = wr && idx == IDX_POST_DETECT_TIMEOUT;

  assign flags_a = {op_state_settled, receive_settled, transmit_settled, synth_locked_flag,
                    level_flag, timeout_flag, intermediate_state_flag, frame_start_detected};
  assign flags_b = {queue_full_flag, queue_occupied_flag, queue_above_mark_flag,
                    queue_overflow_flag, frame_transmitted_flag, frame_received_flag,
                    check_pass_flag, 1'b0};

  // Reads only select; no flag is touched by a read
  assign rd_byte = idx == IDX_MEASURED_LEVEL ? measured_level :
                   idx == IDX_PIN_FUNCTION_SELECT_A ? pin_function_select_a :
                   idx == IDX_PIN_FUNCTION_SELECT_B ?
                     {pin_function_select_b[5:2], 1'b0, ref_divider_select} :
                   idx == IDX_EVENT_FLAGS_A ? flags_a :
                   idx == IDX_EVENT_FLAGS_B ? flags_b :
                   idx == IDX_SIGNAL_LEVEL_THRESHOLD ? level_trigger :
                   idx == IDX_RECEIVE_START_TIMEOUT ? listen_start_limit :
                   post_detect_limit; // see RQ23

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc && !mapped;
      prdata <= (acc && mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_function_select_a <= RST_PIN_MAP; // see RQ1
      pin_function_select_b <= RST_PIN_MAP[7:2]; // see RQ1
      ref_divider_select <= RST_REF_DIVIDER; // see RQ2
      level_trigger <= RST_LEVEL_TRIGGER; // see RQ18
      listen_start_limit <= RST_TIMEOUT;
      post_detect_limit <= RST_TIMEOUT;
      measured_level <= RST_MEASURED_LEVEL; // see RQ22
    end
    else
    begin
      if (wr_a)
        pin_function_select_a <= pwdata[7:0];
      if (wr_b)
      begin
        pin_function_select_b <= {pwdata[7:4], 2'h0};
        ref_divider_select <= pwdata[2:0];
      end
      if (wr_th)
        level_trigger <= pwdata[7:0];
      if (wr_t1)
        listen_start_limit <= pwdata[7:0];
      if (wr_t2)
        post_detect_limit <= pwdata[7:0];
      if (level_valid)
        measured_level <= level_sample; // see RQ22
    end
  end

  // Mode tracking
  logic in_rx;
  logic in_tx;
  logic mode_change;
  logic enter_rx;
  logic leave_rx;
  logic mode_met;
  logic level_hit;
  logic level_event;
  logic fifo_emptied;
  logic frame_ok;
  logic check_fail;
  logic st_fire;
  logic pd_fire;
  assign in_rx = op_mode == MODE_RX;
  assign in_tx = op_mode == MODE_TX;
  assign mode_change = op_mode != prev_mode;
  assign enter_rx = in_rx && prev_mode != MODE_RX;
  assign leave_rx = !in_rx && prev_mode == MODE_RX;
  assign mode_met = (op_mode == MODE_STANDBY && xo_running) ||
                    (op_mode == MODE_SYNTH && pll_locked) ||
                    (in_rx && sampling_started) ||
                    (in_tx && pa_ramp_done); // see RQ3
  // Level above trigger means a smaller magnitude code
  assign level_hit = in_rx && level_valid && level_sample < level_trigger; // see RQ7
  assign level_event = level_hit && !level_flag;
  assign fifo_emptied = queue_occupied_flag && fifo_count == 7'h00;
  assign check_fail = in_rx && rx_last_byte && crc_on && !crc_good;
  assign frame_ok = in_rx && rx_last_byte &&
                    (!crc_on || crc_good || keep_on_check_fail); // see RQ16
  assign st_fire = st_run && bit_tick && tmo_due(st_cnt, listen_start_limit);
  assign pd_fire = pd_run && bit_tick && tmo_due(pd_cnt, post_detect_limit);

  // Status flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_mode <= MODE_SLEEP;
      op_state_settled <= 1'b1; // see RQ3
      receive_settled <= 1'b0;
      transmit_settled <= 1'b0;
      synth_locked_flag <= 1'b0;
      intermediate_state_flag <= 1'b0;
      queue_full_flag <= 1'b0;
      queue_occupied_flag <= 1'b0;
      queue_above_mark_flag <= 1'b0;
    end
    else
    begin
      prev_mode <= op_mode;
      if (mode_change)
        op_state_settled <= op_mode == MODE_SLEEP; // see RQ3
      else if (mode_met)
        op_state_settled <= 1'b1; // see RQ3
      receive_settled <= in_rx && (receive_settled || rx_chain_done); // see RQ4
      transmit_settled <= in_tx && (transmit_settled || pa_ramp_done); // see RQ5
      synth_locked_flag <= pll_locked && (op_mode == MODE_SYNTH || in_rx || in_tx); // see RQ6
      intermediate_state_flag <= intermediate_active; // see RQ9
      queue_full_flag <= 32'(fifo_count) == QUEUE_DEPTH; // see RQ11
      queue_occupied_flag <= fifo_count != 7'h00; // see RQ12
      queue_above_mark_flag <= fifo_count > queue_watermark; // see RQ13
    end
  end

  // Event flags; a set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_flag <= 1'b0;
      timeout_flag <= 1'b0;
      frame_start_detected <= 1'b0;
      queue_overflow_flag <= 1'b0;
      frame_transmitted_flag <= 1'b0;
      frame_received_flag <= 1'b0;
      check_pass_flag <= 1'b0;
    end
    else
    begin
      if (level_hit)
        level_flag <= 1'b1; // see RQ7
      else if (leave_rx || (wr_fa && pwdata[BIT_LEVEL]))
        level_flag <= 1'b0; // see RQ7
      if (st_fire || pd_fire)
        timeout_flag <= 1'b1; // see RQ8
      else if (leave_rx || fifo_emptied)
        timeout_flag <= 1'b0; // see RQ8
      if (in_rx && sync_seen && (!addr_filter_on || addr_ok))
        frame_start_detected <= 1'b1; // see RQ10
      else if (leave_rx || fifo_emptied ||
               (!packet_mode && wr_fa && pwdata[BIT_FRAME_START]))
        frame_start_detected <= 1'b0; // see RQ10
      if (fifo_overrun && op_mode != MODE_SLEEP)
        queue_overflow_flag <= 1'b1; // see RQ14
      else if (wr_fb && pwdata[BIT_OVERFLOW])
        queue_overflow_flag <= 1'b0; // see RQ14
      if (in_tx && tx_frame_done)
        frame_transmitted_flag <= 1'b1; // see RQ15
      else if (!in_tx)
        frame_transmitted_flag <= 1'b0; // see RQ15
      if (frame_ok)
        frame_received_flag <= 1'b1; // see RQ16
      else if (fifo_count == 7'h00)
        frame_received_flag <= 1'b0; // see RQ16
      if (in_rx && rx_last_byte && crc_on && crc_good)
        check_pass_flag <= 1'b1; // see RQ17
      else if (fifo_count == 7'h00)
        check_pass_flag <= 1'b0; // see RQ17
    end
  end

  // Queue flush and reception restart strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_flush <= 1'b0;
      restart_rx <= 1'b0;
    end
    else
    begin
      fifo_flush <= (wr_fb && pwdata[BIT_OVERFLOW]) ||
                    (check_fail && !keep_on_check_fail); // see RQ14 see RQ21
      restart_rx <= check_fail && !keep_on_check_fail; // see RQ21
    end
  end

  // Receive timeouts counted in bit periods
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_run <= 1'b0;
      st_cnt <= 12'h000;
      pd_run <= 1'b0;
      pd_cnt <= 12'h000;
    end
    else
    begin
      if (enter_rx)
      begin
        st_run <= listen_start_limit != 8'h00; // see RQ19
        st_cnt <= 12'h000;
      end
      else if (!in_rx || level_event || st_fire)
        st_run <= 1'b0; // see RQ19
      else if (st_run && bit_tick)
        st_cnt <= st_cnt + 12'h001;
      if (level_event)
      begin
        pd_run <= post_detect_limit != 8'h00; // see RQ20
        pd_cnt <= 12'h000;
      end
      else if (!in_rx || frame_ok || pd_fire)
        pd_run <= 1'b0; // see RQ20
      else if (pd_run && bit_tick)
        pd_cnt <= pd_cnt + 12'h001;
    end
  end

  // Pin routing
  logic [11:0] routes;
  logic [5:0] pin_pick;
  assign routes = {pin_function_select_a, pin_function_select_b[5:2]};
  for (genvar k = 0; k < 6; k++)
  begin : g_pin
    assign pin_pick[k] = route_src[4 * k + int'(routes[11 - 2 * k -: 2])]; // see RQ1 see RQ24
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_out <= 6'h00;
    else
      pin_out <= pin_pick;
  end
  rfp_clk_div u_clk_div (
    .pclk(pclk),
    .presetn(presetn),
    .ref_tick(ref_tick),
    .rc_osc_in(rc_osc_in),
    .ref_divider_select(ref_divider_select),
    .clk_out(clk_out),
    .rc_osc_enable(rc_osc_enable)
  );

endmodule

// >>> test/rfp_flags_monitor.sv
module rfp_flags_chk
  import rfp_pkg::*;
(
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Receive side
  input wire logic [2:0] op_mode,
  input wire logic rx_last_byte,
  input wire logic crc_on,
  input wire logic crc_good,
  input wire logic keep_on_check_fail,
  input wire logic fifo_flush,
  input wire logic restart_rx,
  // Clock output
  input wire logic rc_osc_in,
  input wire logic clk_out,
  input wire logic rc_osc_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire take = psel && penable && !pready;
  wire bad = paddr < 8'h90 || paddr > 8'hac || paddr[1:0] != 2'h0;
  wire w1c = psel && penable && pready && pwrite && paddr == 8'ha0 && pwdata[4];
  wire fail = op_mode == MODE_RX && rx_last_byte && crc_on && !crc_good && !keep_on_check_fail;
  a_answer_next: assert property (take |=> pready)
    else $error("no answer one cycle after access");
  a_answer_pulse: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  a_err_decode: assert property (take |=> pslverr == $past(bad))
    else $error("error response does not match address");
  a_err_nodata: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_flush_w1c: assert property (w1c |-> ##[1:2] fifo_flush)
    else $error("overflow clear did not flush queue");
  a_flush_pulse: assert property (fifo_flush |=> !fifo_flush)
    else $error("flush held too long");
  a_fail_restart: assert property (fail |-> ##[1:2] restart_rx)
    else $error("failed check did not restart reception");
  a_fail_flush: assert property (fail |-> ##[1:2] fifo_flush)
    else $error("failed check did not flush queue");
  a_rc_follow: assert property (
    rc_osc_enable && $past(rc_osc_enable) |-> clk_out == $past(rc_osc_in))
    else $error("clock output not following oscillator");
endmodule

bind rfp_flags rfp_flags_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .op_mode, .rx_last_byte, .crc_on, .crc_good,
  .keep_on_check_fail, .fifo_flush, .restart_rx, .rc_osc_in, .clk_out, .rc_osc_enable);

// >>> test/rfp_modem_model.sv
module rfp_modem_model
  import rfp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Queue control
  input wire logic load,
  input wire logic [6:0] load_val,
  input wire logic fifo_flush,
  // To block
  output logic [6:0] fifo_count,
  output logic bit_tick,
  output logic ref_tick,
  output logic rc_osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div <= 4'h0;
      fifo_count <= 7'h00;
    end
    else
    begin
      div <= div + 4'h1;
      if (fifo_flush)
        fifo_count <= 7'h00;
      else if (load)
        fifo_count <= load_val;
    end
  end
  // One bit period every four cycles
  assign bit_tick = div[1:0] == 2'h3;
  assign ref_tick = div[0];
  assign rc_osc_in = div[2] ^ div[3];
endmodule

// >>> test/tb_top.sv
module tb_top
  import rfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic ia, xo, pll, crc_on, crc_good, keep, load, flush, rst_rx;
  logic pm, af, aok;
  logic bit_tick, ref_tick, rc_osc_in, clk_out, rc_en;
  logic [7:0] paddr, ls, v, ev;
  logic [31:0] pwdata, prdata;
  logic [2:0] op_mode;
  logic [6:0] fifo_count, load_val, wm, c;
  logic [23:0] rs;
  logic [5:0] pin_out;
  logic [16:0] expq[$];
  logic [16:0] e;
  logic [7:0] rst_v[8] = '{8'hff, 8'h00, 8'h07, 8'h80, 8'h00, 8'he4, 8'h00, 8'h00};
  int fails, checks_done, cyc, seed;

  // Pulses: overrun, sent, ramp, last byte, level, sync, sampling, chain
  rfp_flags dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_mode, .intermediate_active(ia), .packet_mode(pm),
    .xo_running(xo), .pll_locked(pll), .sampling_started(ev[6]), .rx_chain_done(ev[7]),
    .pa_ramp_done(ev[2]), .level_valid(ev[4]), .level_sample(ls), .bit_tick,
    .sync_seen(ev[5]), .addr_filter_on(af), .addr_ok(aok), .fifo_count,
    .queue_watermark(wm), .fifo_overrun(ev[0]), .tx_frame_done(ev[1]),
    .rx_last_byte(ev[3]), .crc_on, .crc_good, .keep_on_check_fail(keep),
    .fifo_flush(flush), .restart_rx(rst_rx), .route_src(rs), .pin_out, .ref_tick,
    .rc_osc_in, .clk_out, .rc_osc_enable(rc_en));
  rfp_modem_model peer (.pclk, .presetn, .load, .load_val, .fifo_flush(flush),
    .fifo_count, .bit_tick, .ref_tick, .rc_osc_in);

  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Expected note: error bit, compare mask, value
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
    input logic [16:0] x);
    expq.push_back(x);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'($random(seed)), d};
    tick(1);
    penable <= 1'b1;
    do
      tick(1);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    apb(a, 1'b0, 8'h00, {1'b0, m, x});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 17'h0);
  endtask
  task automatic pulse(input logic [7:0] m);
    ev <= m;
    tick(1);
    ev <= 8'h00;
    tick(2);
  endtask
  // Counts clock output toggles over 64 cycles for one select code
  task automatic clk_toggles(input logic [2:0] s, input logic [8:0] n);
    logic last;
    logic [8:0] t;
    wr(8'h98, {5'h00, s});
    tick(40);
    t = 9'h000;
    @(negedge pclk);
    last = clk_out;
    repeat (64)
    begin
      @(negedge pclk);
      t += 9'(clk_out != last);
      last = clk_out;
    end
    chk(t, n);
    chk({8'h00, rc_en}, {8'h00, s == CLK_SEL_RC});
    tick(1);
  endtask
  task automatic fill(input logic [6:0] n);
    load_val <= n;
    load <= 1'b1;
    tick(1);
    load <= 1'b0;
    tick(2);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(negedge pclk)
    if (pready === 1'b1)
    begin
      e = expq.pop_front();
      chk({pslverr, prdata[7:0] & e[15:8]}, {e[16], e[7:0]});
    end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    seed = 79603;
    presetn = 1'b0;
    {psel, penable, pwrite, ia, xo, pll, crc_on, crc_good, keep, load, af, aok} = '0;
    pm = 1'b1;
    {paddr, ls, pwdata, op_mode, ev, load_val, wm, rs} = '0;
    tick(5);
    presetn <= 1'b1;
    foreach (rst_v[i])
      rd(8'h90 + 8'(4 * i), 8'hff, rst_v[i]);
    for (int i = 5; i < 8; i++)
    begin
      v = 8'($random(seed));
      wr(8'h90 + 8'(4 * i), v);
      rd(8'h90 + 8'(4 * i), 8'hff, v);
    end
    wr(8'h90, 8'h00);
    rd(8'h90, 8'hff, 8'hff);
    wr(8'h9c, 8'hff);
    rd(8'h9c, 8'hff, 8'h80);
    apb(8'h8c, 1'b1, 8'h5a, {1'b1, 16'h0});
    apb(8'h91, 1'b0, 8'h00, {1'b1, 16'h0});
    wr(8'h94, 8'h1b);
    wr(8'h98, 8'hb6);
    rd(8'h98, 8'hff, 8'hb6);
    repeat (4)
    begin
      rs <= 24'($random(seed));
      tick(3);
      chk({3'h0, pin_out}, {3'h0, rs[23], rs[18], rs[15], rs[10], rs[5], rs[0]});
    end
    clk_toggles(3'h6, 9'h008);
    clk_toggles(3'h1, 9'h010);
    clk_toggles(3'h3, 9'h004);
    clk_toggles(3'h7, 9'h000);
    chk({8'h00, clk_out}, 9'h000);
    wm <= 7'(1 + {$random(seed)} % 60);
    tick(1);
    for (int i = 0; i < 6; i++)
    begin
      c = (i < 2) ? 7'(i) : (i < 4) ? wm + 7'(i - 2) : 7'(61 + i);
      fill(c);
      rd(8'ha0, 8'he0, {c == 7'd66, c != 7'd0, c > wm, 5'h0});
    end
    pulse(8'h01);
    rd(8'ha0, 8'h10, 8'h00);
    op_mode <= MODE_STANDBY;
    pulse(8'h01);
    rd(8'ha0, 8'h50, 8'h50);
    wr(8'ha0, 8'h10);
    rd(8'ha0, 8'hf0, 8'h00);
    op_mode <= MODE_SYNTH;
    pll <= 1'b1;
    tick(2);
    rd(8'h9c, 8'h90, 8'h90);
    pll <= 1'b0;
    tick(2);
    rd(8'h9c, 8'h10, 8'h00);
    op_mode <= MODE_TX;
    pulse(8'h06);
    rd(8'h9c, 8'h20, 8'h20);
    rd(8'ha0, 8'h08, 8'h08);
    op_mode <= MODE_STANDBY;
    tick(2);
    rd(8'h9c, 8'h20, 8'h00);
    rd(8'ha0, 8'h08, 8'h00);
    wr(8'hac, 8'h00);
    wr(8'ha8, 8'h01);
    op_mode <= MODE_RX;
    tick(50);
    rd(8'h9c, 8'h04, 8'h00);
    tick(20);
    rd(8'h9c, 8'h04, 8'h04);
    ia <= 1'b1;
    tick(2);
    rd(8'h9c, 8'h02, 8'h02);
    ia <= 1'b0;
    op_mode <= MODE_STANDBY;
    tick(2);
    rd(8'h9c, 8'h06, 8'h00);
    wr(8'ha8, 8'h00);
    wr(8'hac, 8'h02);
    wr(8'ha4, 8'h80);
    op_mode <= MODE_RX;
    ls <= 8'hc0;
    pulse(8'h10);
    rd(8'h9c, 8'h08, 8'h00);
    ls <= 8'h40;
    pulse(8'h10);
    rd(8'h90, 8'hff, 8'h40);
    rd(8'h9c, 8'h0c, 8'h08);
    tick(130);
    rd(8'h9c, 8'h04, 8'h04);
    wr(8'h9c, 8'h08);
    rd(8'h9c, 8'h0c, 8'h04);
    af <= 1'b1;
    pulse(8'h20);
    rd(8'h9c, 8'h01, 8'h00);
    aok <= 1'b1;
    pulse(8'h20);
    wr(8'h9c, 8'h01);
    rd(8'h9c, 8'h01, 8'h01);
    pm <= 1'b0;
    wr(8'h9c, 8'h01);
    rd(8'h9c, 8'h01, 8'h00);
    pm <= 1'b1;
    pulse(8'h20);
    crc_on <= 1'b1;
    crc_good <= 1'b1;
    fill(4);
    pulse(8'hc8);
    rd(8'h9c, 8'hc0, 8'hc0);
    rd(8'ha0, 8'h06, 8'h06);
    fill(0);
    rd(8'ha0, 8'h06, 8'h00);
    rd(8'h9c, 8'h05, 8'h00);
    crc_good <= 1'b0;
    keep <= 1'b1;
    fill(4);
    pulse(8'h08);
    rd(8'ha0, 8'h06, 8'h04);
    fill(0);
    keep <= 1'b0;
    fill(4);
    pulse(8'h08);
    rd(8'ha0, 8'h46, 8'h00);
    xo <= 1'b1;
    op_mode <= MODE_STANDBY;
    tick(2);
    rd(8'h9c, 8'hff, 8'h80);
    finish_test();
  end
endmodule
